// ==== sfw_pkg.sv ====
/*
 Constants of the serial flag word block: register map, bit positions,
 reset value and bus responses. Assumes 32-bit AXI4-Lite data.
*/
package sfw_pkg;
  // register byte offsets
  localparam logic [7:0] SFW_OFF_FLAG = 8'h00;
  localparam logic [7:0] SFW_OFF_CTRL = 8'h04;
  localparam logic [7:0] SFW_OFF_FMT  = 8'h08;
  localparam logic [7:0] SFW_OFF_TXW  = 8'h0C;
  localparam logic [7:0] SFW_OFF_RXW  = 8'h10;
  // flag word
  localparam logic [7:0] SFW_FLAG_RST = 8'h84;
  localparam int SFW_B_TXE  = 7;
  localparam int SFW_B_RXF  = 6;
  localparam int SFW_B_OVR  = 5;
  localparam int SFW_B_FRM  = 4;
  localparam int SFW_B_PAR  = 3;
  localparam int SFW_B_DONE = 2;
  localparam int SFW_B_RMP  = 1;
  localparam int SFW_B_TMP  = 0;
  localparam int SFW_NSTAT  = 5;
  // control word bits
  localparam int SFW_C_TXA = 0;
  localparam int SFW_C_RXA = 1;
  // format word bits
  localparam int SFW_F_SYNC  = 0;
  localparam int SFW_F_PEN   = 1;
  localparam int SFW_F_ODD   = 2;
  localparam int SFW_F_MP    = 3;
  localparam int SFW_F_STOP2 = 4;
  localparam logic [1:0] SFW_CTRL_RST = 2'h0;
  localparam logic [4:0] SFW_FMT_RST  = 5'h00;
  // bus responses
  localparam logic [1:0] SFW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SFW_RESP_SLVERR = 2'h2;
endpackage

// ==== sfw_flag_cell.sv ====
/*
 One software-clearable status flag with read-before-clear arming.
 Assumes strobes come from logic on clk_sys.
*/
`timescale 1ns/100ps
module sfw_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic init,
  // events
  input  wire logic hw_set,
  input  wire logic rd_stb,
  input  wire logic wr0,
  // state
  output logic      flag_q,
  output logic      arm_q,
  output logic      sw_clr
);
  logic flag_d;
  logic arm_d;

  assign sw_clr = wr0 & arm_q & flag_q & ~hw_set; // RULE_03
  assign flag_d = hw_set | (flag_q & ~sw_clr); // RULE_02
  assign arm_d  = flag_d & ((rd_stb & flag_q) | (arm_q & ~wr0)); // RULE_19

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= RST_VAL;
      arm_q  <= 1'b0;
    end else if (clk_en) begin
      flag_q <= init ? RST_VAL : flag_d;
      arm_q  <= init ? 1'b0 : arm_d;
    end
  end
endmodule

// ==== sfw_rx_check.sv ====
/*
 Framing and parity check of one received character.
 Assumes inputs are stable in the cycle the frame completes.
*/
`timescale 1ns/100ps
module sfw_rx_check #(
  parameter int DATA_W = 8
) (
  // frame
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              rx_par_bit,
  input  wire logic              rx_stop_bit,
  // format
  input  wire logic              async_mode,
  input  wire logic              par_en,
  input  wire logic              par_odd,
  // results
  output logic                   frm_err,
  output logic                   par_err
);
  logic [DATA_W:0] chain;

  assign chain[0] = rx_par_bit;
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_par
      assign chain[i+1] = chain[i] ^ rx_data[i];
    end
  endgenerate

  // only the first stop bit is presented here
  assign frm_err = async_mode & ~rx_stop_bit; // RULE_12 RULE_13
  assign par_err = async_mode & par_en & (chain[DATA_W] ^ par_odd); // RULE_15
endmodule

// ==== sfw_top.sv ====
/*
 Serial flag word with receive/transmit event handling and an AXI4-Lite
 register slave. Assumes shifter and receiver events are one-cycle
 pulses on clk_sys and standby is a synchronous level.
*/
// Function
// [RULE_01] 8-bit flag word, resets to 0x84
// [RULE_02] writing 1 to status flags ignored
// [RULE_03] clear by zero only after read-as-one
// [RULE_04] transmit done, received mp bit read-only
// [RULE_05] holding-to-shifter move sets buffer empty
// [RULE_06] transmit disabled forces buffer empty
// [RULE_07] good frame sets receive buffer full
// [RULE_08] errors, receive disable keep holding data
// [RULE_09] frame while full: overrun, discard new
// [RULE_10] overrun/framing halt receiver, sync transmitter
// [RULE_11] receive disable keeps error flags
// [RULE_12] zero stop bit sets framing error
// [RULE_13] only first stop bit checked
// [RULE_14] framing error loads data, not full
// [RULE_15] parity mismatch sets parity error
// [RULE_16] transmit done on last bit when empty
// [RULE_17] capture received mp bit in mp format
// [RULE_18] transmit mp bit sent from bit 0
// [RULE_19] clear only flags read as one
// [RULE_20] reads only arm the clear
`timescale 1ns/100ps
module sfw_top
  import sfw_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              standby,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // transmit shifter
  input  wire logic              tx_load,
  input  wire logic              tx_last_bit,
  output logic [DATA_W-1:0]      tx_word_q,
  output logic                   tx_mp_bit_q,
  output logic                   tx_run_q,
  // receiver
  input  wire logic              rx_done,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              rx_par_bit,
  input  wire logic              rx_stop_bit,
  input  wire logic              rx_mp_bit,
  output logic                   rx_accept_q
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]        flags;
  logic [1:0]        ctrl_q;
  logic [4:0]        fmt_q;
  logic [DATA_W-1:0] rxw_q;
  logic              done_q;
  logic              rmp_q;
  logic              tmp_q;
  logic              awready_q;
  logic              arready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [SFW_NSTAT-1:0] st_set;
  logic [SFW_NSTAT-1:0] st_arm;
  logic [SFW_NSTAT-1:0] st_clr;
  logic [SFW_NSTAT-1:0] st_wr0;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_hs    = s_axi_awvalid & awready_q & s_axi_wvalid;
  wire rd_hs    = s_axi_arvalid & arready_q;
  wire wr_flag  = wr_hs & (s_axi_awaddr == ADDR_W'(SFW_OFF_FLAG));
  wire wr_ctrl  = wr_hs & (s_axi_awaddr == ADDR_W'(SFW_OFF_CTRL));
  wire wr_fmt   = wr_hs & (s_axi_awaddr == ADDR_W'(SFW_OFF_FMT));
  wire wr_txw   = wr_hs & (s_axi_awaddr == ADDR_W'(SFW_OFF_TXW));
  wire wr_rxw   = wr_hs & (s_axi_awaddr == ADDR_W'(SFW_OFF_RXW));
  wire wr_map   = wr_flag | wr_ctrl | wr_fmt | wr_txw | wr_rxw;
  wire wr_lane  = s_axi_wstrb[0];
  wire rd_flag  = rd_hs & (s_axi_araddr == ADDR_W'(SFW_OFF_FLAG));
  wire rd_ctrl  = rd_hs & (s_axi_araddr == ADDR_W'(SFW_OFF_CTRL));
  wire rd_fmt   = rd_hs & (s_axi_araddr == ADDR_W'(SFW_OFF_FMT));
  wire rd_txw   = rd_hs & (s_axi_araddr == ADDR_W'(SFW_OFF_TXW));
  wire rd_rxw   = rd_hs & (s_axi_araddr == ADDR_W'(SFW_OFF_RXW));
  wire rd_map   = rd_flag | rd_ctrl | rd_fmt | rd_txw | rd_rxw;
  wire [31:0] rd_mux =
      rd_flag ? {24'h000000, flags} :
      rd_ctrl ? {30'h0, ctrl_q} :
      rd_fmt  ? {27'h0, fmt_q} :
      rd_txw  ? 32'(tx_word_q) :
      rd_rxw  ? 32'(rxw_q) : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // configuration
  wire tx_allowed = ctrl_q[SFW_C_TXA];
  wire rx_allowed = ctrl_q[SFW_C_RXA];
  wire sync_mode  = fmt_q[SFW_F_SYNC];
  wire mp_mode    = fmt_q[SFW_F_MP] & ~sync_mode;
  wire err_any    = flags[SFW_B_OVR] | flags[SFW_B_FRM] | flags[SFW_B_PAR];
  wire rx_ok      = rx_allowed & ~err_any; // RULE_10
  wire take       = rx_done & rx_ok;
  wire rxf        = flags[SFW_B_RXF];
  wire frm_c;
  wire par_c;

  sfw_rx_check #(
    .DATA_W(DATA_W)
  ) u_check (
    .rx_data    (rx_data),
    .rx_par_bit (rx_par_bit),
    .rx_stop_bit(rx_stop_bit),
    .async_mode (~sync_mode),
    .par_en     (fmt_q[SFW_F_PEN]),
    .par_odd    (fmt_q[SFW_F_ODD]),
    .frm_err    (frm_c),
    .par_err    (par_c)
  );

  ////////////////////////////////////////////////////////////////////////
  // flag events
  wire rx_load = take & ~rxf; // RULE_08 RULE_14
  assign st_set[SFW_B_TXE-SFW_B_PAR] = tx_load | ~tx_allowed; // RULE_05 RULE_06
  assign st_set[SFW_B_RXF-SFW_B_PAR] = rx_load & ~frm_c & ~par_c; // RULE_07 RULE_14
  assign st_set[SFW_B_OVR-SFW_B_PAR] = take & rxf; // RULE_09
  assign st_set[SFW_B_FRM-SFW_B_PAR] = rx_load & frm_c; // RULE_12
  assign st_set[SFW_B_PAR-SFW_B_PAR] = rx_load & par_c; // RULE_15
  wire done_set = (tx_last_bit & flags[SFW_B_TXE]) | ~tx_allowed; // RULE_16
  wire done_clr = st_clr[SFW_B_TXE-SFW_B_PAR] & ~done_set;

  genvar g;
  generate
    for (g = 0; g < SFW_NSTAT; g++) begin : g_flag
      assign st_wr0[g] = wr_flag & wr_lane & ~s_axi_wdata[SFW_B_PAR+g]; // RULE_02
      sfw_flag_cell #(
        .RST_VAL(SFW_FLAG_RST[SFW_B_PAR+g])
      ) u_cell (
        .clk_sys(clk_sys),
        .rst    (rst),
        .clk_en (clk_en),
        .init   (standby),
        .hw_set (st_set[g]),
        .rd_stb (rd_flag), // RULE_20
        .wr0    (st_wr0[g]),
        .flag_q (flags[SFW_B_PAR+g]),
        .arm_q  (st_arm[g]),
        .sw_clr (st_clr[g])
      );
    end
  endgenerate

  assign flags[SFW_B_DONE] = done_q;
  assign flags[SFW_B_RMP]  = rmp_q;
  assign flags[SFW_B_TMP]  = tmp_q;

  ////////////////////////////////////////////////////////////////////////
  // fixed and data registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done_q <= SFW_FLAG_RST[SFW_B_DONE]; // RULE_01
      rmp_q  <= SFW_FLAG_RST[SFW_B_RMP];
      tmp_q  <= SFW_FLAG_RST[SFW_B_TMP];
    end else if (clk_en) begin
      if (standby) begin
        done_q <= SFW_FLAG_RST[SFW_B_DONE]; // RULE_01
        rmp_q  <= SFW_FLAG_RST[SFW_B_RMP];
        tmp_q  <= SFW_FLAG_RST[SFW_B_TMP];
      end else begin
        done_q <= done_set | (done_q & ~done_clr); // RULE_04 RULE_16
        if (rx_load & mp_mode) begin
          rmp_q <= rx_mp_bit; // RULE_17
        end
        if (wr_flag & wr_lane) begin
          tmp_q <= s_axi_wdata[SFW_B_TMP];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q    <= SFW_CTRL_RST;
      fmt_q     <= SFW_FMT_RST;
      tx_word_q <= '0;
      rxw_q     <= '0;
    end else if (clk_en) begin
      if (wr_ctrl & wr_lane) begin
        ctrl_q <= s_axi_wdata[1:0]; // RULE_11
      end
      if (wr_fmt & wr_lane) begin
        fmt_q <= s_axi_wdata[4:0];
      end
      if (wr_txw & wr_lane) begin
        tx_word_q <= s_axi_wdata[DATA_W-1:0];
      end
      if (rx_load) begin
        rxw_q <= rx_data; // RULE_08 RULE_09
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_mp_bit_q <= 1'b0;
      tx_run_q    <= 1'b0;
      rx_accept_q <= 1'b0;
    end else if (clk_en) begin
      tx_mp_bit_q <= mp_mode & tmp_q; // RULE_18
      tx_run_q    <= tx_allowed & ~(sync_mode & err_any); // RULE_10
      rx_accept_q <= rx_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= SFW_RESP_OKAY;
    end else if (clk_en) begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      if (wr_hs) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? SFW_RESP_OKAY : SFW_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= SFW_RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else if (clk_en) begin
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rd_hs) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_map ? SFW_RESP_OKAY : SFW_RESP_SLVERR;
        rdata_q  <= rd_mux; // RULE_20
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_read_full;
    clk_en & rd_flag & rxf & ~st_clr[SFW_B_RXF-SFW_B_PAR] & ~standby;
  endsequence
  sequence s_zero_full;
    clk_en & st_wr0[SFW_B_RXF-SFW_B_PAR] & st_arm[SFW_B_RXF-SFW_B_PAR] & rxf
    & ~st_set[SFW_B_RXF-SFW_B_PAR] & ~standby;
  endsequence

  a_standby_init: assert property ( // RULE_01
    clk_en & standby |=> flags == SFW_FLAG_RST)
    else $error("flag word not initialised by standby");
  a_one_ignored: assert property ( // RULE_02
    clk_en & wr_flag & ~standby & ~rxf & ~st_set[SFW_B_RXF-SFW_B_PAR] |=> ~rxf)
    else $error("write of one set a status flag");
  a_clear_unread: assert property ( // RULE_03
    clk_en & flags[SFW_B_OVR] & ~st_arm[SFW_B_OVR-SFW_B_PAR] & ~standby
    |=> flags[SFW_B_OVR])
    else $error("unread error flag was cleared");
  a_read_clear: assert property ( // RULE_19
    s_zero_full |=> ~rxf)
    else $error("read then zero did not clear full flag");
  a_read_arm: assert property ( // RULE_20
    s_read_full |=> st_arm[SFW_B_RXF-SFW_B_PAR])
    else $error("read of full flag did not arm clear");
  a_done_ro: assert property ( // RULE_04
    clk_en & wr_flag & ~standby & tx_allowed & ~tx_last_bit & ~done_clr
    |=> done_q == $past(done_q))
    else $error("transmit done changed by write");
  a_txe_forced: assert property ( // RULE_06
    clk_en & ~tx_allowed |=> flags[SFW_B_TXE] & done_q)
    else $error("disabled transmitter not empty");
  a_overrun_keep: assert property ( // RULE_09
    clk_en & take & rxf & ~standby |=> flags[SFW_B_OVR] & rxf & $stable(rxw_q))
    else $error("overrun handling wrong");
  a_error_halt: assert property ( // RULE_10
    clk_en & err_any & rx_done & ~standby |=> $stable(rxw_q) ##1 ~rx_accept_q)
    else $error("receiver not halted by error");
  a_frame_load: assert property ( // RULE_14
    clk_en & take & ~rxf & frm_c & ~standby
    |=> flags[SFW_B_FRM] & ~rxf & rxw_q == $past(rx_data))
    else $error("framing error load wrong");
  a_txe_load: assert property ( // RULE_05
    clk_en & tx_load & ~standby |=> flags[SFW_B_TXE])
    else $error("shifter load did not set buffer empty");
  a_full_set: assert property ( // RULE_07
    clk_en & take & ~rxf & ~frm_c & ~par_c & ~standby |=> rxf & rxw_q == $past(rx_data))
    else $error("good frame did not set full flag");
  a_parity_set: assert property ( // RULE_15
    clk_en & take & ~rxf & par_c & ~standby |=> flags[SFW_B_PAR] & ~rxf)
    else $error("parity error handling wrong");
  a_done_last: assert property ( // RULE_16
    clk_en & tx_last_bit & flags[SFW_B_TXE] & ~standby |=> done_q)
    else $error("last bit with empty buffer did not set done");
  a_mp_capture: assert property ( // RULE_17
    clk_en & rx_load & mp_mode & ~standby |=> rmp_q == $past(rx_mp_bit))
    else $error("received mp bit not captured");
endmodule

// ==== sfw_far_end.sv ====
/*
 Remote serial device model: finishes one frame per send request.
 Assumes send is a one-cycle pulse driven on clk_sys.
*/
`timescale 1ns/100ps
module sfw_far_end (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // request: data, {parity, first stop, mp}
  input  wire logic       send,
  input  wire logic [7:0] f_data,
  input  wire logic [2:0] f_bits,
  // frame to receiver
  output logic            rx_done,
  output logic [7:0]      rx_data,
  output logic            rx_par_bit,
  output logic            rx_stop_bit,
  output logic            rx_mp_bit
);
  logic [10:0] fld_q;

  assign {rx_data, rx_par_bit, rx_stop_bit, rx_mp_bit} = fld_q;

  // fields toggle outside the done cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_done <= 1'b0;
      fld_q   <= 11'h000;
    end else begin
      rx_done <= send;
      fld_q   <= send ? {f_data, f_bits} : ~fld_q;
    end
  end
endmodule

// ==== sfw_top_bench.sv ====
/*
 Random walk over bus accesses, frames and shifter events, checked
 against a flag model. Assumes a 40 MHz clk_sys.
*/
`timescale 1ns/100ps
module sfw_top_bench;
  import sfw_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        standby = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        tx_load = 1'b0;
  logic        tx_last_bit = 1'b0;
  logic        send = 1'b0;
  logic [7:0]  f_data = 8'h00;
  logic [2:0]  f_bits = 3'h2;
  logic [7:0]  tx_word_q, rx_data;
  logic        tx_mp_bit_q, tx_run_q, rx_accept_q;
  logic        rx_done, rx_par_bit, rx_stop_bit, rx_mp_bit;
  // model state
  logic [7:0]  ef, eh, ew;
  logic [4:0]  arm, fmt;
  logic [1:0]  ctl, r;
  logic [31:0] v;
  logic        en = 1'b1;
  int          n_mismatch = 0;
  int          n_tests = 0;

  always #12.5 clk_sys = ~clk_sys;

  sfw_top #(.ADDR_W(8), .DATA_W(8)) dut_u (
    .clk_sys, .rst, .clk_en, .standby,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_load, .tx_last_bit, .tx_word_q,
    .tx_mp_bit_q, .tx_run_q, .rx_done, .rx_data, .rx_par_bit, .rx_stop_bit,
    .rx_mp_bit, .rx_accept_q
  );

  sfw_far_end far_u (
    .clk_sys, .rst, .send, .f_data, .f_bits,
    .rx_done, .rx_data, .rx_par_bit, .rx_stop_bit, .rx_mp_bit
  );

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic errs();
    return |ef[5:3];
  endfunction

  function automatic logic par_bad(input logic [7:0] d, input logic p, input logic odd);
    return (^{d, p}) != odd;
  endfunction

  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(negedge clk_sys); while (s_axi_awready !== 1'b1);
    chk("wready", 32'h1, 32'(s_axi_wready));
    @(posedge clk_sys);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    {rs, d} = {s_axi_rresp, s_axi_rdata};
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask

  task automatic hold();
    if (!ctl[0]) {ef[7], ef[2]} = 2'h3;
  endtask

  task automatic rdf();
    rd(SFW_OFF_FLAG, v, r);
    chk("flag_word", 32'(ef), v);
    arm = ef[7:3];
    @(negedge clk_sys);
    chk("rx_accept", 32'(ctl[1] & ~errs()), 32'(rx_accept_q));
    chk("tx_run", 32'(ctl[0] & ~(fmt[0] & errs())), 32'(tx_run_q));
    chk("tx_mp", 32'(ef[0] & ~fmt[0] & fmt[3]), 32'(tx_mp_bit_q));
  endtask

  task automatic wf(input logic [7:0] d);
    wr(SFW_OFF_FLAG, 32'(d), r);
    chk("bresp", 32'(SFW_RESP_OKAY), 32'(r));
    if (arm[4] & ~d[7]) ef[2] = 1'b0;
    ef[7:3] = ef[7:3] & ~(arm & ~d[7:3]);
    {ef[0], arm} = {d[0], 5'h0};
    hold();
  endtask

  task automatic cfg(input logic [1:0] c, input logic [4:0] f);
    if (f[3]) f[1] = 1'b0;
    wr(SFW_OFF_CTRL, 32'(c), r);
    wr(SFW_OFF_FMT, 32'(f), r);
    {ctl, fmt} = {c, f};
    hold();
  endtask

  // b is {parity, first stop, mp}
  task automatic frm(input logic [7:0] d, input logic [2:0] b);
    @(posedge clk_sys);
    {send, f_data, f_bits} <= {1'b1, d, b};
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (2) @(posedge clk_sys);
    if (en && ctl[1] && !errs()) begin
      if (ef[6]) begin
        ef[5] = 1'b1;
      end else begin
        eh = d;
        if (!fmt[0] && fmt[3]) ef[1] = b[0];
        if (!fmt[0] && !b[1]) ef[4] = 1'b1;
        if (!fmt[0] && fmt[1] && par_bad(d, b[2], fmt[2])) ef[3] = 1'b1;
        if (!(ef[4] | ef[3])) ef[6] = 1'b1;
      end
    end
  endtask

  task automatic txe(input logic ld);
    @(posedge clk_sys);
    {tx_load, tx_last_bit} <= {ld, ~ld};
    @(posedge clk_sys);
    {tx_load, tx_last_bit} <= 2'h0;
    @(posedge clk_sys);
    if (en && ld) ef[7] = 1'b1;
    if (en && !ld && ef[7]) ef[2] = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    n_mismatch++;
    summarize();
  end

  initial begin
    {ef, eh, arm, ctl, fmt} = {8'h84, 8'h00, 5'h0, 2'h0, 5'h00};
    void'($urandom(94895));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rdf();
    rd(8'h20, v, r);
    chk("rresp", 32'(SFW_RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, v);
    wr(8'h24, 32'h0, r);
    chk("bresp", 32'(SFW_RESP_SLVERR), 32'(r));
    wf(8'hFF);
    rdf();
    cfg(2'h3, 5'h00);
    wf(8'h00);
    rdf();
    wf(8'h00);
    rdf();
    ew = 8'($urandom);
    wr(SFW_OFF_TXW, 32'(ew), r);
    rd(SFW_OFF_TXW, v, r);
    chk("tx_word", 32'(ew), v);
    chk("tx_word_q", 32'(ew), 32'(tx_word_q));
    s_axi_wstrb <= 4'h0;
    wr(SFW_OFF_TXW, 32'(~ew), r);
    s_axi_wstrb <= 4'hF;
    chk("bresp", 32'(SFW_RESP_OKAY), 32'(r));
    rd(SFW_OFF_TXW, v, r);
    chk("tx_word", 32'(ew), v);
    for (int i = 0; i < 400; i++) begin
      case ($urandom_range(0, 7))
        0, 1: frm(8'($urandom), {1'($urandom), $urandom_range(0, 3) != 0, 1'($urandom)});
        2: txe(1'($urandom));
        3: begin
          rdf();
          if ($urandom_range(0, 1) == 1) frm(8'($urandom), 3'h2);
          wf(8'($urandom));
        end
        4: begin
          rd(SFW_OFF_RXW, v, r);
          chk("rx_word", 32'(eh), v);
        end
        5: cfg(2'($urandom), 5'($urandom));
        6: begin
          standby <= 1'b1;
          @(posedge clk_sys);
          standby <= 1'b0;
          {ef, arm} = {8'h84, 5'h0};
        end
        default: begin
          en = 1'b0;
          clk_en <= 1'b0;
          frm(8'($urandom), 3'h2);
          txe(1'b1);
          en = 1'b1;
          clk_en <= 1'b1;
        end
      endcase
      rdf();
    end
    summarize();
  end
endmodule
